// ---- logic/ixs_pkg.sv ----
// Purpose: Constants and types for the extender sequencing and timing block
// Assumes: 100 MHz hclk, AHB-Lite register access, word transfers only
// Notes:   Long counts are overridable by module parameters
package ixs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // --------------------------------------------------------------
    // Sequencing times
    // --------------------------------------------------------------
    localparam int unsigned T_ON_LOW_US       = 1;
    localparam int unsigned T_READY_US        = 65;
    localparam int unsigned T_REMOTE_RESET_MS = 180;
    localparam real         T_TIMEOUT_MS      = 31.5;
    localparam int unsigned T_IDLE_US         = 70;

    localparam int unsigned ON_LOW_CYC = T_ON_LOW_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned READY_CYC  = T_READY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned RRESET_CYC = T_REMOTE_RESET_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TMO_CYC    = int'(T_TIMEOUT_MS * 1000000.0 / CLK_PERIOD_NS);
    localparam int unsigned IDLE_CYC   = (T_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LCNT_W     = 25;

    // --------------------------------------------------------------
    // Controller phase times in ns, index 0 Sm, 1 Fm, 2 Fm+
    // --------------------------------------------------------------
    localparam int unsigned LOW_NS   [3] = '{5800, 1500, 600};
    localparam int unsigned HIGH_NS  [3] = '{4200, 1000, 400};
    localparam int unsigned HDSTA_NS [3] = '{4200, 800, 300};
    localparam int unsigned SUSTO_NS [3] = '{4200, 800, 300};
    localparam int unsigned SUSTA_NS [3] = '{4800, 800, 300};
    localparam int unsigned BUF_NS   [3] = '{5000, 1500, 600};
    localparam int unsigned TMR_W        = 16;

    localparam logic [1:0] PROF_SM  = 2'h0;
    localparam logic [1:0] PROF_FM  = 2'h1;
    localparam logic [1:0] PROF_FMP = 2'h2;

    // --------------------------------------------------------------
    // Register map and fields
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD     = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h10;

    localparam logic [1:0] OP_BIT     = 2'h0;
    localparam logic [1:0] OP_START   = 2'h1;
    localparam logic [1:0] OP_STOP    = 2'h2;
    localparam logic [1:0] OP_RESTART = 2'h3;
    localparam int unsigned CMD_DATA_BIT = 8;

    localparam int unsigned IRQ_TMO   = 0;
    localparam int unsigned IRQ_DONE  = 1;
    localparam int unsigned IRQ_RRST  = 2;
    localparam int unsigned IRQ_READY = 3;
    localparam int unsigned IRQ_N     = 4;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_START = 8'h02,
        ST_HELD  = 8'h04,
        ST_LOW   = 8'h08,
        ST_HIGH  = 8'h10,
        ST_STO   = 8'h20,
        ST_RSU   = 8'h40,
        ST_BUF   = 8'h80
    } ixs_state_t;

    function automatic logic [TMR_W-1:0] ixs_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c == 0) c = 1;
        return TMR_W'(c);
    endfunction : ixs_cyc

endpackage : ixs_pkg

// ---- logic/ixs_seq_timing.sv ----
// Purpose: Power-on, ready and remote-reset sequencing plus bus timing
// Assumes: Pins are asynchronous and pass two flip-flops first
// Notes:   Remote-mode controller steps are issued one at a time by software
`timescale 1ns/1ps
module ixs_seq_timing
    import ixs_pkg::*;
#(
    parameter int unsigned P_READY_CYC  = READY_CYC,
    parameter int unsigned P_RRESET_CYC = RRESET_CYC,
    parameter int unsigned P_TMO_CYC    = TMO_CYC,
    parameter int unsigned P_IDLE_CYC   = IDLE_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        power_on,
    input  wire logic        node_remote,
    input  wire logic        link_rate_select_a,
    input  wire logic        link_rate_select_b,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    output logic             ready_n,
    output logic             remote_reset,
    output logic             irq
);

    typedef struct packed {
        logic              on_m, on_s, role_m, role_s;
        logic              sa_m, sa_s, sb_m, sb_s;
        logic              scl_m, scl_s, sda_m, sda_s;
        logic [1:0]        prof;
        logic [LCNT_W-1:0] on_low_cnt;
        logic [LCNT_W-1:0] rdy_cnt;
        logic              ready_n;
        logic              rreset;
        logic [LCNT_W-1:0] scl_lo_cnt;
        logic [LCNT_W-1:0] scl_hi_cnt;
        logic              bus_idle;
        ixs_state_t        st;
        logic [TMR_W-1:0]  tmr;
        logic [1:0]        op;
        logic              dbit;
        logic              rxbit;
        logic              busy;
        logic              scl_oe_n;
        logic              sda_oe_n;
        logic [IRQ_N-1:0]  irq_sts;
        logic [IRQ_N-1:0]  irq_en;
        logic              irq;
        logic              wr_pend;
        logic [7:0]        wr_addr;
        logic [31:0]       hrdata;
    } ixs_regs_t;

    ixs_regs_t s_r;
    ixs_regs_t s_nxt;

    function automatic logic [LCNT_W-1:0] sat_inc(input logic [LCNT_W-1:0] v,
                                                  input logic [LCNT_W-1:0] lim);
        return (v >= lim) ? lim : v + LCNT_W'(1);
    endfunction : sat_inc

    function automatic logic [1:0] prof_dec(input logic a, input logic b);
        return a ? PROF_FMP : (b ? PROF_FM : PROF_SM);
    endfunction : prof_dec

    function automatic logic [TMR_W-1:0] phase_len(input logic [1:0] p, input ixs_state_t st);
        int unsigned i;
        i = (p == PROF_FMP) ? 2 : ((p == PROF_FM) ? 1 : 0);
        case (st)
            ST_LOW:   return ixs_cyc(LOW_NS[i]);
            ST_HIGH:  return ixs_cyc(HIGH_NS[i]);
            ST_START: return ixs_cyc(HDSTA_NS[i]);
            ST_STO:   return ixs_cyc(SUSTO_NS[i]);
            ST_RSU:   return ixs_cyc(SUSTA_NS[i]);
            ST_BUF:   return ixs_cyc(BUF_NS[i]);
            default:  return TMR_W'(1);
        endcase
    endfunction : phase_len

    logic soft_rst;
    logic abort;
    logic tmr_run;
    logic tmr_done;

    always_comb begin
        logic [IRQ_N-1:0] evt;
        logic [IRQ_N-1:0] clr;
        evt   = '0;
        clr   = '0;
        s_nxt = s_r;

        s_nxt.on_m   = power_on;
        s_nxt.on_s   = s_r.on_m;
        s_nxt.role_m = node_remote;
        s_nxt.role_s = s_r.role_m;
        s_nxt.sa_m   = link_rate_select_a;
        s_nxt.sa_s   = s_r.sa_m;
        s_nxt.sb_m   = link_rate_select_b;
        s_nxt.sb_s   = s_r.sb_m;
        s_nxt.scl_m  = scl_in;
        s_nxt.scl_s  = s_r.scl_m;
        s_nxt.sda_m  = sda_in;
        s_nxt.sda_s  = s_r.sda_m;
        s_nxt.prof   = prof_dec(s_r.sa_s, s_r.sb_s);

        // ----------------------------------------------------------
        // Power-on sequencing
        // ----------------------------------------------------------
        // Short low pulses ignored
        soft_rst = !s_r.on_s && (s_r.on_low_cnt >= LCNT_W'(ON_LOW_CYC));
        if (!s_r.on_s) begin
            s_nxt.on_low_cnt = sat_inc(s_r.on_low_cnt, LCNT_W'(P_RRESET_CYC));
        end else begin
            s_nxt.on_low_cnt = '0;
        end
        if (s_r.on_s) begin
            s_nxt.rreset = 1'b0;
        end else if (!s_r.role_s && !s_r.rreset
                     && s_nxt.on_low_cnt == LCNT_W'(P_RRESET_CYC)) begin
            s_nxt.rreset  = 1'b1;
            evt[IRQ_RRST] = 1'b1;
        end
        if (soft_rst) begin
            s_nxt.rdy_cnt = '0;
            s_nxt.ready_n = 1'b1;
        end else if (s_r.on_s) begin
            s_nxt.rdy_cnt = sat_inc(s_r.rdy_cnt, LCNT_W'(P_READY_CYC));
            if (s_r.ready_n && s_r.rdy_cnt == LCNT_W'(P_READY_CYC)
                && (s_r.role_s || s_r.bus_idle)) begin
                s_nxt.ready_n  = 1'b0;
                evt[IRQ_READY] = 1'b1;
            end
        end

        // ----------------------------------------------------------
        // Clock line watch
        // ----------------------------------------------------------
        if (!s_r.scl_s) begin
            s_nxt.scl_lo_cnt = sat_inc(s_r.scl_lo_cnt, LCNT_W'(P_TMO_CYC));
            s_nxt.scl_hi_cnt = '0;
        end else begin
            s_nxt.scl_lo_cnt = '0;
            s_nxt.scl_hi_cnt = sat_inc(s_r.scl_hi_cnt, LCNT_W'(P_IDLE_CYC));
        end
        if (s_nxt.scl_lo_cnt == LCNT_W'(P_TMO_CYC) && s_r.scl_lo_cnt != LCNT_W'(P_TMO_CYC)) begin
            evt[IRQ_TMO] = 1'b1;
        end
        s_nxt.bus_idle = (s_nxt.scl_hi_cnt == LCNT_W'(P_IDLE_CYC));

        // ----------------------------------------------------------
        // Remote-mode controller
        // ----------------------------------------------------------
        abort = soft_rst || !s_r.role_s || evt[IRQ_TMO];
        // High, stop-setup and restart-setup phases wait while the clock is stretched; start hold and bus free do not
        tmr_run  = !(s_r.st inside {ST_HIGH, ST_STO, ST_RSU}) || s_r.scl_s;
        tmr_done = tmr_run && (s_r.tmr == phase_len(s_r.prof, s_r.st) - TMR_W'(1));
        if (tmr_run) begin
            s_nxt.tmr = tmr_done ? '0 : s_r.tmr + TMR_W'(1);
        end
        if (abort) begin
            s_nxt.st       = ST_IDLE;
            s_nxt.busy     = 1'b0;
            s_nxt.scl_oe_n = 1'b1;
            s_nxt.sda_oe_n = 1'b1;
            s_nxt.tmr      = '0;
        end else begin
            case (s_r.st)
                ST_IDLE: begin
                    s_nxt.tmr = '0;
                    if (s_r.busy && s_r.op != OP_START) begin
                        s_nxt.busy = 1'b0;
                    end else if (s_r.busy && s_r.bus_idle) begin
                        s_nxt.st       = ST_START;
                        s_nxt.sda_oe_n = 1'b0;
                    end
                end
                ST_START: if (tmr_done) begin
                    s_nxt.st       = ST_HELD;
                    s_nxt.scl_oe_n = 1'b0;
                    s_nxt.busy     = 1'b0;
                    evt[IRQ_DONE]  = 1'b1;
                end
                ST_HELD: begin
                    s_nxt.tmr = '0;
                    if (s_r.busy && s_r.op == OP_START) begin
                        s_nxt.busy = 1'b0;
                    end else if (s_r.busy) begin
                        s_nxt.st       = ST_LOW;
                        s_nxt.sda_oe_n = (s_r.op == OP_BIT) ? s_r.dbit : (s_r.op != OP_STOP);
                    end
                end
                // Low then high fill one period
                ST_LOW: if (tmr_done) begin
                    s_nxt.scl_oe_n = 1'b1;
                    s_nxt.st = (s_r.op == OP_BIT) ? ST_HIGH
                             : ((s_r.op == OP_STOP) ? ST_STO : ST_RSU);
                end
                ST_HIGH: if (tmr_done) begin
                    s_nxt.rxbit    = s_r.sda_s;
                    s_nxt.scl_oe_n = 1'b0;
                    s_nxt.st       = ST_HELD;
                    s_nxt.busy     = 1'b0;
                    evt[IRQ_DONE]  = 1'b1;
                end
                ST_STO: if (tmr_done) begin
                    s_nxt.sda_oe_n = 1'b1;
                    s_nxt.st       = ST_BUF;
                end
                ST_RSU: if (tmr_done) begin
                    s_nxt.sda_oe_n = 1'b0;
                    s_nxt.st       = ST_START;
                end
                ST_BUF: if (tmr_done) begin
                    s_nxt.st      = ST_IDLE;
                    s_nxt.busy    = 1'b0;
                    evt[IRQ_DONE] = 1'b1;
                end
                default: begin
                    s_nxt.st = ST_IDLE;
                end
            endcase
        end

        // ----------------------------------------------------------
        // Bus slave
        // ----------------------------------------------------------
        s_nxt.wr_pend = hsel && htrans[1] && hready && hwrite;
        s_nxt.wr_addr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                ADDR_STATUS:  s_nxt.hrdata = {24'h0, s_r.rreset, !s_r.ready_n, s_r.prof,
                                              s_r.role_s, s_r.bus_idle, s_r.rxbit, s_r.busy};
                ADDR_IRQ_STS: s_nxt.hrdata = {28'h0, s_r.irq_sts};
                ADDR_IRQ_EN:  s_nxt.hrdata = {28'h0, s_r.irq_en};
                default:      s_nxt.hrdata = 32'h0;
            endcase
        end
        if (s_r.wr_pend) begin
            case (s_r.wr_addr)
                ADDR_CMD: if (!s_r.busy && s_r.role_s && !abort) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.op   = hwdata[1:0];
                    s_nxt.dbit = hwdata[CMD_DATA_BIT];
                end
                ADDR_IRQ_CLR: clr = hwdata[IRQ_N-1:0];
                ADDR_IRQ_EN:  s_nxt.irq_en = hwdata[IRQ_N-1:0];
                default: ;
            endcase
        end
        // Set beats clear when both land together
        s_nxt.irq_sts = (s_r.irq_sts & ~clr) | evt;
        s_nxt.irq     = |(s_nxt.irq_sts & s_nxt.irq_en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r          <= '0;
            s_r.st       <= ST_IDLE;
            s_r.ready_n  <= 1'b1;
            s_r.scl_oe_n <= 1'b1;
            s_r.sda_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Zero wait states, so ready never drops
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s_r.hrdata;
    assign scl_out      = 1'b0;
    assign sda_out      = 1'b0;
    assign scl_oe_n     = s_r.scl_oe_n;
    assign sda_oe_n     = s_r.sda_oe_n;
    assign ready_n      = s_r.ready_n;
    assign remote_reset = s_r.rreset;
    assign irq          = s_r.irq;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_ready_delay: assert property ($fell(s_r.ready_n) |->
        $past(s_r.rdy_cnt) == LCNT_W'(P_READY_CYC) && $past(s_r.on_s))
        else $error("ready asserted before delay");
    chk_remote_reset: assert property ($rose(s_r.rreset) |->
        s_r.on_low_cnt == LCNT_W'(P_RRESET_CYC) && !$past(s_r.role_s))
        else $error("remote reset without long low");
    chk_timeout_flag: assert property (
        s_r.scl_lo_cnt == LCNT_W'(P_TMO_CYC) && $past(s_r.scl_lo_cnt) != LCNT_W'(P_TMO_CYC)
        |-> s_r.irq_sts[IRQ_TMO])
        else $error("timeout not flagged");
    chk_idle_detect: assert property ($rose(s_r.bus_idle) |->
        s_r.scl_hi_cnt == LCNT_W'(P_IDLE_CYC) && $past(s_r.scl_s))
        else $error("idle too early");
    chk_scl_low: assert property (s_r.st == ST_LOW && s_nxt.st == ST_HIGH |->
        s_r.tmr == phase_len(s_r.prof, ST_LOW) - TMR_W'(1) && !s_r.scl_oe_n ##1 s_r.scl_oe_n)
        else $error("clock low phase short");
    chk_bus_free: assert property (s_r.st == ST_BUF && s_nxt.st == ST_IDLE |->
        s_r.tmr == phase_len(s_r.prof, ST_BUF) - TMR_W'(1) && s_r.sda_oe_n)
        else $error("bus free time short");
    chk_start_hold: assert property ($rose(s_r.st == ST_HELD) && $past(s_r.st) == ST_START
        |-> $past(s_r.tmr) == phase_len(s_r.prof, ST_START) - TMR_W'(1)
        && !s_r.sda_oe_n && !s_r.scl_oe_n)
        else $error("start hold short");
    chk_rs_setup: assert property (s_r.st == ST_RSU && s_nxt.st == ST_START |->
        s_r.scl_s && s_r.sda_oe_n ##1 !s_r.sda_oe_n)
        else $error("repeated start setup broken");
    chk_profile_sel: assert property (##2 s_r.prof ==
        prof_dec($past(s_r.sa_s), $past(s_r.sb_s)))
        else $error("profile not from selects");

    cov_remote_reset: cover property ($rose(s_r.rreset));
    cov_timeout:      cover property ($rose(s_r.irq_sts[IRQ_TMO]));
    cov_stop_done:    cover property (s_r.st == ST_BUF ##1 s_r.st == ST_IDLE);
    cov_restart:      cover property (s_r.st == ST_RSU ##1 s_r.st == ST_START);

endmodule : ixs_seq_timing

// ---- verification/ixs_bus_model.sv ----
// Purpose: Open-drain clock and data lines with far-side targets
// Assumes: Pull-ups release both lines high
// Notes:   hold_scl and hold_sda let a target pull a line low on command
`timescale 1ns/1ps
module ixs_bus_model (
    input  wire logic scl_oe_n,
    input  wire logic sda_oe_n,
    input  wire logic hold_scl,
    input  wire logic hold_sda,
    output logic      scl,
    output logic      sda
);
    // ----------------------------------------------------------
    // Wired-AND lines
    // ----------------------------------------------------------
    // Target may stretch
    assign scl = scl_oe_n & ~hold_scl;
    // Target data wired-AND with ours
    assign sda = sda_oe_n & ~hold_sda;
endmodule : ixs_bus_model

// ---- verification/ixs_seq_timing_tb.sv ----
// Purpose: Self-checking bench for ixs_seq_timing
// Assumes: Short sequencing counts set by parameters
// Notes:   Phase times measured in hclk cycles of 10 ns
`timescale 1ns/1ps
module ixs_seq_timing_tb
    import ixs_pkg::*;
();
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    localparam int unsigned RDY = 20;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        power_on = 1'b0, node_remote = 1'b0, hold_scl = 1'b0, hold_sda = 1'b0;
    logic        rate_a = 1'b0, rate_b = 1'b0;
    logic        hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic        ready_n, remote_reset, irq, scl, sda;
    logic [31:0] hrdata;
    logic        scl_q = 1'b1, sda_q = 1'b1;
    integer      seed = 32'hde82;
    int          n_errors = 0, cmp_count = 0, t_scl = 0, t_sda = 0;
    int          hi_len, lo_len, hd_len, su_sto, su_sta, buf_len;
    bit          q[$];
    // Minimum and typical phase cycles, index 0 Sm, 1 Fm, 2 Fm+
    int          hd_mn[3] = '{400, 60, 26}, hd_ty[3] = '{420, 80, 30};
    int          sa_mn[3] = '{470, 60, 26}, sa_ty[3] = '{480, 80, 30};
    int          bf_mn[3] = '{470, 130, 50}, per[3] = '{1000, 250, 100};

    always #5 hclk = ~hclk;

    // Timeout must outlast the slowest low phase plus polling
    ixs_seq_timing #(.P_READY_CYC(RDY), .P_RRESET_CYC(200), .P_TMO_CYC(1000),
                     .P_IDLE_CYC(30)) i_ixs_seq_timing (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .power_on(power_on), .node_remote(node_remote),
        .link_rate_select_a(rate_a), .link_rate_select_b(rate_b),
        .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ready_n(ready_n),
        .remote_reset(remote_reset), .irq(irq));

    ixs_bus_model i_ixs_bus_model (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
                                   .hold_scl(hold_scl), .hold_sda(hold_sda),
                                   .scl(scl), .sda(sda));

    // Edge-to-edge phase lengths of what the device drives
    always @(posedge hclk) begin
        t_scl = t_scl + 1;
        t_sda = t_sda + 1;
        if (scl_oe_n !== scl_q) begin
            if (scl_q) hi_len = t_scl;
            else lo_len = t_scl;
            if (scl_q && !sda_oe_n) hd_len = t_sda;
            t_scl = 0;
        end
        if (sda_oe_n !== sda_q && scl_oe_n) begin
            if (sda_oe_n) su_sto = t_scl;
            else begin
                su_sta = t_scl;
                buf_len = t_sda;
            end
        end
        if (sda_oe_n !== sda_q) t_sda = 0;
        scl_q = scl_oe_n;
        sda_q = sda_oe_n;
    end

    // ----------------------------------------------------------
    // Bench tasks
    // ----------------------------------------------------------
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    task automatic wait_rdy;
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        n_errors++;
        print_verdict();
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask : rdm

    // Software waits on busy; no fixed command length assumed
    task automatic cmd(input logic [1:0] op, input logic b);
        logic [31:0] r;
        ahb(1'b1, ADDR_CMD, (32'(b) << CMD_DATA_BIT) | 32'(op), r);
        for (int i = 0; i < 3000; i++) begin
            ahb(1'b0, ADDR_STATUS, 32'h0, r);
            if (r[0] === 1'b0) return;
        end
        n_errors++;
        print_verdict();
    endtask : cmd

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        int i, k;
        logic b, t;
        cyc(6);
        hresetn <= 1'b1;
        cyc(1);
        chk({ready_n, remote_reset, irq}, 3'b100);
        rdm(8'h20, 32'hffffffff, 32'h0);
        rdm(ADDR_IRQ_EN, 32'hf, 32'h0);
        cyc(130);
        chk(remote_reset, 1'b0);
        cyc(80);
        rdm(ADDR_STATUS, 32'h88, 32'h80);
        chk(remote_reset, 1'b1);
        power_on <= 1'b1;
        for (i = 0; i < 100 && ready_n !== 1'b0; i++) cyc(1);
        if (i == 100) begin
            n_errors++;
            print_verdict();
        end
        chk_rng(i, RDY, RDY + 5);
        chk({remote_reset, hresp, scl_out, sda_out}, 4'h0);
        rdm(ADDR_IRQ_STS, 32'hf, 32'hc);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_EN, 32'h8);
        cyc(2);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_CLR, 32'hf);
        cyc(2);
        chk(irq, 1'b0);
        power_on <= 1'b0;
        cyc(50);
        power_on <= 1'b1;
        cyc(10);
        chk(ready_n, 1'b0);
        power_on <= 1'b0;
        cyc(120);
        chk(ready_n, 1'b1);
        power_on <= 1'b1;
        cyc(40);
        chk(ready_n, 1'b0);
        wr(ADDR_IRQ_EN, 32'h2);
        wr(ADDR_IRQ_CLR, 32'hf);
        hold_scl <= 1'b1;
        cyc(980);
        rdm(ADDR_IRQ_STS, 32'h1, 32'h0);
        cyc(40);
        rdm(ADDR_IRQ_STS, 32'h1, 32'h1);
        hold_scl <= 1'b0;
        cyc(15);
        rdm(ADDR_STATUS, 32'h4, 32'h0);
        cyc(30);
        rdm(ADDR_STATUS, 32'h4, 32'h4);
        node_remote <= 1'b1;
        cyc(4);
        rdm(ADDR_STATUS, 32'h8, 32'h8);
        wr(ADDR_IRQ_CLR, 32'hf);
        cmd(OP_BIT, 1'b1);
        rdm(ADDR_IRQ_STS, 32'h2, 32'h0);
        for (int p = 0; p < 4; p++) begin
            rate_a <= p[1];
            rate_b <= p[0];
            k = p[1] ? 2 : p[0];
            cyc(4);
            rdm(ADDR_STATUS, 32'h30, 32'(k) << 4);
            cmd(OP_START, 1'b0);
            chk_rng(hd_len, hd_mn[k], hd_ty[k] + 4);
            // Start while holding the bus is refused
            wr(ADDR_IRQ_CLR, 32'h2);
            cmd(OP_START, 1'b0);
            rdm(ADDR_IRQ_STS, 32'h2, 32'h0);
            b = 1'($random(seed));
            t = 1'($random(seed));
            q.push_back(b & ~t);
            hold_sda <= t;
            cmd(OP_BIT, b);
            hold_sda <= 1'b0;
            chk_rng(hi_len + lo_len, per[k], per[k] + 100);
            rdm(ADDR_STATUS, 32'h2, 32'(q.pop_front()) << 1);
            cmd(OP_RESTART, 1'b1);
            chk_rng(su_sta, sa_mn[k], sa_ty[k] + 4);
            chk_rng(hd_len, hd_mn[k], hd_ty[k] + 4);
            cmd(OP_STOP, 1'b0);
            chk_rng(su_sto, hd_mn[k], hd_ty[k] + 4);
            cmd(OP_START, 1'b0);
            chk_rng(buf_len, bf_mn[k], bf_mn[k] + 1000);
            cmd(OP_STOP, 1'b0);
        end
        chk(irq, 1'b1);
        wr(ADDR_IRQ_CLR, 32'h2);
        cyc(2);
        chk(irq, 1'b0);
        print_verdict();
    end
endmodule : ixs_seq_timing_tb
